//--- ccpu_defines.vh
// Constants for the capture/compare/PWM unit: register map, fields, modes
`ifndef CCPU_DEFINES_VH
`define CCPU_DEFINES_VH

// ----------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------
`define CCPU_OFS_CTRL0     8'h00
`define CCPU_OFS_CTRL1     8'h04
`define CCPU_OFS_VALUE0    8'h08
`define CCPU_OFS_VALUE1    8'h0c
`define CCPU_OFS_TA_COUNT  8'h10
`define CCPU_OFS_TB_COUNT  8'h14
`define CCPU_OFS_TB_PERIOD 8'h18
`define CCPU_OFS_INT_STAT  8'h1c
`define CCPU_OFS_INT_CLR   8'h20
`define CCPU_OFS_INT_EN    8'h24
`define CCPU_OFS_TIMER_CTL 8'h28

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CCPU_CTRL_W      8
`define CCPU_CTRL_MASK   8'h3f
`define CCPU_CTRL_RST    8'h00
`define CCPU_MODE_HI     3
`define CCPU_DUTY_HI     5
`define CCPU_DUTY_LO     4
`define CCPU_VAL_W       16
`define CCPU_VAL_RST     16'h0000
`define CCPU_TB_W        8
`define CCPU_TB_RST      8'h00
`define CCPU_TB_PER_RST  8'hff
`define CCPU_SUB_LAST    2'h3
`define CCPU_INT_W       3
`define CCPU_INT_TB      2
`define CCPU_TCTL_W      2
`define CCPU_TCTL_TA_RUN 0
`define CCPU_TCTL_TB_RUN 1
`define CCPU_ZERO32      32'h0000_0000

// ----------------------------------------
// Mode field encodings
// ----------------------------------------
`define CCPU_M_OFF       4'h0
`define CCPU_M_TOGGLE    4'h2
`define CCPU_M_CAP_FALL  4'h4
`define CCPU_M_CAP_RISE  4'h5
`define CCPU_M_CAP_4TH   4'h6
`define CCPU_M_CAP_16TH  4'h7
`define CCPU_M_CMP_SET   4'h8
`define CCPU_M_CMP_CLR   4'h9
`define CCPU_M_CMP_INT   4'ha
`define CCPU_M_CMP_TRIG  4'hb
`define CCPU_PRE_W       4
`define CCPU_PRE_4TH     4'h3
`define CCPU_PRE_16TH    4'hf
`define CCPU_PRE_ONE     4'h1
`define CCPU_PRE_ZERO    4'h0

// ----------------------------------------
// AHB-Lite encodings
// ----------------------------------------
`define CCPU_HTRANS_NSEQ 2'h2
`define CCPU_HRESP_OKAY  1'b0

`endif

//--- ccpu_channel.v
// One capture/compare/PWM channel working from the shared time bases
`timescale 1ns/10ps
`include "ccpu_defines.vh"

module ccpu_channel (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire [7:0] unit_control,
  input wire value_wr,
  input wire [15:0] value_wdata,
  input wire [15:0] timer_a_count,
  input wire [9:0] pwm_base,
  input wire tb_period_evt,
  input wire unit_pin_in,
  output wire [15:0] capture_compare_value,
  output reg unit_pin_out,
  output reg unit_pin_oe_n,
  output reg unit_event,
  output reg unit_trigger
);

  wire [3:0] mode = unit_control[`CCPU_MODE_HI:0];
  wire is_cap = (mode[3:2] == 2'b01);
  wire is_cmp = (mode[3:2] == 2'b10) || (mode == `CCPU_M_TOGGLE);
  wire is_pwm = (mode[3:2] == 2'b11);

  reg [15:0] value_reg;
  reg pin_prev_reg;
  reg [3:0] pre_reg;
  reg match_prev_reg;
  reg [9:0] duty_reg;
  reg [15:0] value_next;
  reg [3:0] pre_next;
  reg cap_fire;
  reg out_next;

  assign capture_compare_value = value_reg;

  wire rise = unit_pin_in & ~pin_prev_reg;
  wire fall = ~unit_pin_in & pin_prev_reg;
  // Compare acts once on arrival at the match, not every cycle the timer dwells there
  wire match = (timer_a_count == value_reg);
  wire cmp_fire = is_cmp & match & ~match_prev_reg;
  wire [9:0] duty_new = {value_reg[7:0], unit_control[`CCPU_DUTY_HI:`CCPU_DUTY_LO]};

  // ----------------------------------------
  // Capture prescaler and event selection
  // ----------------------------------------
  always @* begin
    pre_next = pre_reg;
    cap_fire = 1'b0;
    if (!is_cap) begin
      pre_next = `CCPU_PRE_ZERO;
    end else begin
      case (mode)
        `CCPU_M_CAP_FALL: cap_fire = fall;
        `CCPU_M_CAP_RISE: cap_fire = rise;
        `CCPU_M_CAP_4TH: begin
          if (rise) begin
            pre_next = pre_reg + `CCPU_PRE_ONE;
            cap_fire = ((pre_reg & `CCPU_PRE_4TH) == `CCPU_PRE_4TH);
          end
        end
        `CCPU_M_CAP_16TH: begin
          if (rise) begin
            pre_next = pre_reg + `CCPU_PRE_ONE;
            cap_fire = (pre_reg == `CCPU_PRE_16TH);
          end
        end
        default: cap_fire = 1'b0;
      endcase
    end
    value_next = value_reg;
    if (cap_fire) begin
      value_next = timer_a_count;
    end else if (value_wr) begin
      value_next = value_wdata;
    end
  end

  // ----------------------------------------
  // Output pin behaviour per mode
  // ----------------------------------------
  always @* begin
    out_next = unit_pin_out;
    case (mode)
      `CCPU_M_TOGGLE: if (cmp_fire) out_next = ~unit_pin_out;
      `CCPU_M_CMP_SET: if (cmp_fire) out_next = 1'b1;
      `CCPU_M_CMP_CLR: if (cmp_fire) out_next = 1'b0;
      `CCPU_M_CMP_INT: out_next = unit_pin_out;
      `CCPU_M_CMP_TRIG: out_next = unit_pin_out;
      default: begin
        if (is_pwm) begin
          // Period event starts every PWM output with a nonzero duty in the same cycle
          if (tb_period_evt) out_next = (duty_new != 10'h000);
          else if (pwm_base >= duty_reg) out_next = 1'b0;
        end else begin
          out_next = 1'b0;
        end
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_reg <= `CCPU_VAL_RST;
      pin_prev_reg <= 1'b0;
      pre_reg <= `CCPU_PRE_ZERO;
      match_prev_reg <= 1'b0;
      duty_reg <= 10'h000;
      unit_pin_out <= 1'b0;
      unit_pin_oe_n <= 1'b1;
      unit_event <= 1'b0;
      unit_trigger <= 1'b0;
    end else if (clk_en) begin
      value_reg <= value_next;
      pin_prev_reg <= unit_pin_in;
      pre_reg <= pre_next;
      match_prev_reg <= match;
      // Duty is only taken at the shared period event, so both PWMs update together
      if (tb_period_evt) duty_reg <= duty_new;
      unit_pin_out <= out_next;
      unit_pin_oe_n <= ~(is_cmp | is_pwm);
      unit_event <= cap_fire | cmp_fire;
      unit_trigger <= cmp_fire & (mode == `CCPU_M_CMP_TRIG);
    end
  end

endmodule // ccpu_channel

//--- ccpu_top.v
// Dual capture/compare/PWM unit with shared timers and an AHB-Lite register slave
`timescale 1ns/10ps
`include "ccpu_defines.vh"

module ccpu_top (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [1:0] unit_pin_in,
  output wire [1:0] unit_pin_out,
  output wire [1:0] unit_pin_oe_n,
  output wire [1:0] unit_trigger,
  output wire irq
);

  // ----------------------------------------
  // Bus slave: writes land in the data phase, reads add one wait state
  // ----------------------------------------
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [7:0] addr_reg;
  reg [7:0] ctrl_reg [0:1];
  reg [15:0] ta_reg;
  reg [7:0] tb_reg;
  reg [1:0] tb_sub_reg;
  reg [7:0] tb_per_reg;
  reg [2:0] int_stat_reg;
  reg [2:0] int_en_reg;
  reg [1:0] tctl_reg;
  reg [31:0] rdata_next;
  reg [2:0] stat_next;

  wire [15:0] val [0:1];
  wire [1:0] ev;
  wire [1:0] trig;

  // The read wait state lets a read see a write that finished one cycle earlier
  // Clock enable low also holds the bus, so no transfer is taken and then lost
  // while all state is frozen
  assign hreadyout = ~rd_pend_reg & clk_en;
  assign hresp = `CCPU_HRESP_OKAY;
  assign unit_trigger = trig;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire take = hsel & hready & (htrans == `CCPU_HTRANS_NSEQ);
  wire wr_now = wr_pend_reg & clk_en;
  wire wr_ctrl0 = wr_now & (addr_reg == `CCPU_OFS_CTRL0);
  wire wr_ctrl1 = wr_now & (addr_reg == `CCPU_OFS_CTRL1);
  wire wr_val0 = wr_now & (addr_reg == `CCPU_OFS_VALUE0);
  wire wr_val1 = wr_now & (addr_reg == `CCPU_OFS_VALUE1);
  wire wr_ta = wr_now & (addr_reg == `CCPU_OFS_TA_COUNT);
  wire wr_tb = wr_now & (addr_reg == `CCPU_OFS_TB_COUNT);
  wire wr_per = wr_now & (addr_reg == `CCPU_OFS_TB_PERIOD);
  wire wr_clr = wr_now & (addr_reg == `CCPU_OFS_INT_CLR);
  wire wr_en = wr_now & (addr_reg == `CCPU_OFS_INT_EN);
  wire wr_tctl = wr_now & (addr_reg == `CCPU_OFS_TIMER_CTL);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata <= `CCPU_ZERO32;
    end else if (clk_en) begin
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        hrdata <= rdata_next;
      end else begin
        wr_pend_reg <= take & hwrite;
        rd_pend_reg <= take & ~hwrite;
        // Only the word offset is kept, so upper address bits alias the map
        if (take) addr_reg <= {haddr[7:2], 2'b00};
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Unmapped and write-only offsets read as zero
  always @* begin
    case (addr_reg)
      `CCPU_OFS_CTRL0: rdata_next = {24'h00_0000, ctrl_reg[0]};
      `CCPU_OFS_CTRL1: rdata_next = {24'h00_0000, ctrl_reg[1]};
      `CCPU_OFS_VALUE0: rdata_next = {16'h0000, val[0]};
      `CCPU_OFS_VALUE1: rdata_next = {16'h0000, val[1]};
      `CCPU_OFS_TA_COUNT: rdata_next = {16'h0000, ta_reg};
      `CCPU_OFS_TB_COUNT: rdata_next = {24'h00_0000, tb_reg};
      `CCPU_OFS_TB_PERIOD: rdata_next = {24'h00_0000, tb_per_reg};
      `CCPU_OFS_INT_STAT: rdata_next = {29'h0000_0000, int_stat_reg};
      `CCPU_OFS_INT_EN: rdata_next = {29'h0000_0000, int_en_reg};
      `CCPU_OFS_TIMER_CTL: rdata_next = {30'h0000_0000, tctl_reg};
      default: rdata_next = `CCPU_ZERO32;
    endcase
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg[0] <= `CCPU_CTRL_RST;
      ctrl_reg[1] <= `CCPU_CTRL_RST;
      tb_per_reg <= `CCPU_TB_PER_RST;
      int_en_reg <= 3'h0;
      tctl_reg <= 2'h0;
    end else begin
      if (wr_ctrl0) ctrl_reg[0] <= hwdata[7:0] & `CCPU_CTRL_MASK;
      if (wr_ctrl1) ctrl_reg[1] <= hwdata[7:0] & `CCPU_CTRL_MASK;
      if (wr_per) tb_per_reg <= hwdata[7:0];
      if (wr_en) int_en_reg <= hwdata[2:0];
      if (wr_tctl) tctl_reg <= hwdata[1:0];
    end
  end

  // ----------------------------------------
  // Timer A (capture/compare base) and timer B (PWM base)
  // ----------------------------------------
  // Special trigger restarts timer A so compare can set a repeating interval
  wire ta_clear = |trig;
  // Timer B counts in quarter steps so the duty has two extra low bits
  wire tb_evt = tctl_reg[`CCPU_TCTL_TB_RUN] & (tb_reg == tb_per_reg)
                & (tb_sub_reg == `CCPU_SUB_LAST);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ta_reg <= `CCPU_VAL_RST;
      tb_reg <= `CCPU_TB_RST;
      tb_sub_reg <= 2'h0;
    end else if (clk_en) begin
      if (wr_ta) ta_reg <= hwdata[15:0];
      else if (ta_clear) ta_reg <= `CCPU_VAL_RST;
      else if (tctl_reg[`CCPU_TCTL_TA_RUN]) ta_reg <= ta_reg + 16'h0001;
      // A count write also restarts the quarter steps
      if (wr_tb) begin
        tb_reg <= hwdata[7:0];
        tb_sub_reg <= 2'h0;
      end else if (tb_evt) begin
        tb_reg <= `CCPU_TB_RST;
        tb_sub_reg <= 2'h0;
      end else if (tctl_reg[`CCPU_TCTL_TB_RUN]) begin
        tb_sub_reg <= tb_sub_reg + 2'h1;
        if (tb_sub_reg == `CCPU_SUB_LAST) tb_reg <= tb_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Channels share one timer A and one timer B period event
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
      ccpu_channel u_ch (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .unit_control(ctrl_reg[gi]),
        .value_wr(gi == 0 ? wr_val0 : wr_val1),
        .value_wdata(hwdata[15:0]),
        .timer_a_count(ta_reg),
        .pwm_base({tb_reg, tb_sub_reg}),
        .tb_period_evt(tb_evt),
        .unit_pin_in(unit_pin_in[gi]),
        .capture_compare_value(val[gi]),
        .unit_pin_out(unit_pin_out[gi]),
        .unit_pin_oe_n(unit_pin_oe_n[gi]),
        .unit_event(ev[gi]),
        .unit_trigger(trig[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Sticky interrupt status: a new event wins over a clear in the same cycle
  // ----------------------------------------
  always @* begin
    stat_next = int_stat_reg;
    if (wr_clr) stat_next = int_stat_reg & ~hwdata[2:0];
    if (clk_en) stat_next = stat_next | {tb_evt, ev};
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_reg <= 3'h0;
    end else begin
      int_stat_reg <= stat_next;
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  assign irq = |(int_stat_reg & int_en_reg);

endmodule // ccpu_top

//--- ccpu_pin_model.sv
// Pin-side partner: external event source that yields where the unit drives
`timescale 1ns/10ps

module ccpu_pin_model (
  input wire [1:0] src_level,
  input wire [1:0] pin_out,
  input wire [1:0] pin_oe_n,
  output wire [1:0] pin_in
);
  // ----------------------------------------
  // Wire level
  // ----------------------------------------
  // The unit wins on a bit it drives, so a driving channel sees its own level
  assign pin_in = (pin_out & ~pin_oe_n) | (src_level & pin_oe_n);
endmodule // ccpu_pin_model

//--- ccpu_top_asserts.sv
// Concurrent checks on the ports of the capture/compare/PWM top
`timescale 1ns/10ps

module ccpu_top_asserts (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [1:0] unit_pin_in,
  input wire [1:0] unit_pin_out,
  input wire [1:0] unit_pin_oe_n,
  input wire [1:0] unit_trigger,
  input wire irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_take = hsel && hready && (htrans == 2'h2) && !hwrite && clk_en;
  wire wr_take = hsel && hready && (htrans == 2'h2) && hwrite && clk_en;

  // ----------------------------------------
  // Bus and pin relations
  // ----------------------------------------
  chk_resp_okay: assert property (hresp == 1'h0)
    else $error("bus response not okay");
  chk_read_wait: assert property (rd_take |=> !hreadyout ##1
    (hreadyout == (clk_en && $past(clk_en))))
    else $error("read data phase not one wait state");
  chk_write_nowait: assert property (wr_take |=> (hreadyout == clk_en))
    else $error("write data phase stalled");
  chk_wait_single: assert property ((!hreadyout && clk_en) |=> (hreadyout == clk_en))
    else $error("wait state longer than one cycle");
  chk_freeze_stall: assert property (!clk_en |-> !hreadyout)
    else $error("bus ready while clock enable low");
  // Read data may only move at the edge that ends a wait state
  chk_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  chk_reset_idle: assert property ($rose(hresetn) |-> hreadyout && !irq &&
    unit_trigger == 2'h0 && unit_pin_oe_n == 2'h3 && unit_pin_out == 2'h0)
    else $error("outputs not idle after reset");
  chk_trig_pulse: assert property ((unit_trigger & $past(unit_trigger)) == 2'h0)
    else $error("trigger longer than one cycle");
  chk_trig_drive: assert property ((unit_trigger & unit_pin_oe_n) == 2'h0)
    else $error("trigger outside a driving mode");
endmodule // ccpu_top_asserts

bind ccpu_top ccpu_top_asserts u_chk (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .unit_pin_in,
  .unit_pin_out, .unit_pin_oe_n, .unit_trigger, .irq);

//--- test_capture_compare_pwm_unit.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/10ps
`include "ccpu_defines.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module test_capture_compare_pwm_unit;
  logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0, level = 0, p;
  logic [2:0] hsize = 3'h2;
  logic [15:0] v;
  wire hreadyout, hresp, irq;
  wire [31:0] hrdata;
  wire [1:0] pin_in, pin_out, pin_oe_n, trig;
  int failures = 0, num_checks = 0, d0, d1, pp, r0 = 0, h0 = 0, h1 = 0, tc = 0;
  int t [4];
  logic [3:0] cm [4] = '{4'h4, 4'h6, 4'h7, 4'h5};
  int cn [4] = '{1, 4, 16, 1};
  logic [3:0] km [5] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb};
  logic ko [5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1};

  always #25 hclk = ~hclk;
  // Trigger pulses of channel 0; anything on channel 1 is counted as a gross error
  always @(posedge hclk)
    if (hresetn) tc += (trig === 2'h1) ? 1 : ((trig === 2'h0) ? 0 : 100);

  ccpu_top u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .unit_pin_in(pin_in), .unit_pin_out(pin_out), .unit_pin_oe_n(pin_oe_n),
    .unit_trigger(trig), .irq(irq));
  ccpu_pin_model u_pin (.src_level(level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in));

  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= `CCPU_HTRANS_NSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // One pulse gives exactly one rising and one falling edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      level[0] <= 1'h1;
      repeat (4) @(posedge hclk);
      level[0] <= 1'h0;
      tick(4);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #1_000_000;
    failures++;
    end_sim;
  end

  initial begin
    rd = $urandom(32'h16f93d7e);
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    chkrd(`CCPU_OFS_CTRL0, 32'h0000_0000);
    chkrd(`CCPU_OFS_TB_PERIOD, 32'h0000_00ff);
    chkrd(`CCPU_OFS_INT_STAT, 32'h0000_0000);
    chkrd(8'h3c, 32'h0000_0000);
    wr(`CCPU_OFS_INT_EN, 32'h0000_0001);
    // ----------------------------------------
    // Capture, with a stray pulse before each switch-off, cleared from the prescaler by the switch-off after the 4th and 16th modes
    // ----------------------------------------
    foreach (cm[i]) begin
      v = $urandom;
      pulses(1);
      wr(`CCPU_OFS_CTRL0, 32'h0000_0000);
      wr(`CCPU_OFS_TA_COUNT, v);
      wr(`CCPU_OFS_INT_CLR, 32'h0000_0007);
      wr(`CCPU_OFS_CTRL0, cm[i]);
      pulses(cn[i] - 1);
      chkrd(`CCPU_OFS_INT_STAT, 32'h0000_0000);
      pulses(1);
      chkrd(`CCPU_OFS_INT_STAT, 32'h0000_0001);
      chkrd(`CCPU_OFS_VALUE0, v);
    end
    // A prescale change alone keeps the count: 2 rises in 4th mode, then 14 reach 16
    wr(`CCPU_OFS_CTRL0, 32'h0000_0000);
    wr(`CCPU_OFS_INT_CLR, 32'h0000_0007);
    wr(`CCPU_OFS_CTRL0, 32'h0000_0006);
    pulses(2);
    wr(`CCPU_OFS_CTRL0, 32'h0000_0007);
    pulses(13);
    chkrd(`CCPU_OFS_INT_STAT, 32'h0000_0000);
    pulses(1);
    chkrd(`CCPU_OFS_INT_STAT, 32'h0000_0001);
    // Two captures with no read between: the later one wins
    wr(`CCPU_OFS_CTRL0, 32'h0000_0005);
    wr(`CCPU_OFS_TA_COUNT, $urandom);
    pulses(1);
    v = $urandom;
    wr(`CCPU_OFS_TA_COUNT, v);
    pulses(1);
    chkrd(`CCPU_OFS_VALUE0, v);
    `CHK(irq, 1'h1)
    wr(`CCPU_OFS_INT_EN, 32'h0000_0000);
    `CHK(irq, 1'h0)
    wr(`CCPU_OFS_INT_EN, 32'h0000_0001);
    wr(`CCPU_OFS_INT_CLR, 32'h0000_0007);
    `CHK(irq, 1'h0)
    // ----------------------------------------
    // Compare actions, timer A run across the match
    // ----------------------------------------
    foreach (km[i]) begin
      v = 16'h0100 + $urandom_range(32'h0000_fe00);
      wr(`CCPU_OFS_TIMER_CTL, 32'h0000_0000);
      wr(`CCPU_OFS_INT_CLR, 32'h0000_0007);
      wr(`CCPU_OFS_CTRL0, km[i]);
      wr(`CCPU_OFS_VALUE0, v);
      wr(`CCPU_OFS_TA_COUNT, v - 16'h0008);
      wr(`CCPU_OFS_TIMER_CTL, 32'h0000_0001);
      tick(20);
      `CHK(pin_out[0], ko[i])
      `CHK(tc, km[i] == 4'hb)
      `CHK(pin_oe_n[0], 1'h0)
      chkrd(`CCPU_OFS_INT_STAT, 32'h0000_0001);
    end
    wr(`CCPU_OFS_CTRL0, 32'h0000_0000);
    tick(1);
    `CHK(pin_out[0], 1'h0)
    `CHK(pin_oe_n[0], 1'h1)
    // ----------------------------------------
    // Paired PWM on timer B
    // ----------------------------------------
    d0 = $urandom_range(7, 1);
    d1 = $urandom_range(7, 1);
    pp = $urandom_range(5, 2);
    wr(`CCPU_OFS_TB_PERIOD, pp);
    wr(`CCPU_OFS_VALUE0, d0 >> 2);
    wr(`CCPU_OFS_VALUE1, d1 >> 2);
    wr(`CCPU_OFS_CTRL0, ((d0 & 3) << 4) | 32'h0000_000c);
    wr(`CCPU_OFS_CTRL1, ((d1 & 3) << 4) | 32'h0000_000c);
    wr(`CCPU_OFS_TIMER_CTL, 32'h0000_0002);
    tick(64);
    p = pin_out;
    repeat (4 * (pp + 1)) begin
      tick(1);
      `CHK(pin_out[0] & ~p[0], pin_out[1] & ~p[1])
      r0 += pin_out[0] & ~p[0];
      h0 += pin_out[0];
      h1 += pin_out[1];
      p = pin_out;
    end
    `CHK(r0, 1)
    `CHK(h1 - h0, d1 - d0)
    chkrd(`CCPU_OFS_INT_STAT, 32'h0000_0005);
    // ----------------------------------------
    // Clock enable low freezes timer A: the third gap loses five steps
    // ----------------------------------------
    wr(`CCPU_OFS_TIMER_CTL, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      bus(1'h0, `CCPU_OFS_TA_COUNT, 32'h0000_0000);
      t[i] = rd;
      @(posedge hclk);
      if (i == 2) clk_en <= 1'h0;
      repeat (5) @(posedge hclk);
      clk_en <= 1'h1;
      #1;
    end
    `CHK((t[1] - t[0]) - (t[3] - t[2]), 5)
    end_sim;
  end
endmodule // test_capture_compare_pwm_unit
